//--- cag_circ_addr_gen.sv
// circular buffer and bit-reversed effective address generator with axi4-lite registers
// ==========================================================================
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module cag_circ_addr_gen #(
  parameter int PAGE_W = 9
) (
  input wire logic aclk, // 50 mhz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic req_valid, // address request from datapath
  input wire logic req_write, // request is a data write
  input wire logic req_space_y, // read request targets y space
  input wire logic req_word, // word access (byte access when low)
  input wire logic [2:0] req_mode, // addressing mode, cag_mode_e
  input wire logic [3:0] req_ptr_sel, // pointer register number
  input wire logic [15:0] req_ptr, // pointer register value
  input wire logic [15:0] req_offset, // signed index or literal offset
  output logic ea_valid, // effective address valid, one cycle
  output logic [15:0] ea, // effective address
  output logic [PAGE_W-1:0] ea_page, // page of effective address
  output logic wb_valid, // pointer write-back strobe
  output logic [3:0] wb_ptr_sel, // pointer register to update
  output logic [15:0] wb_ptr // new pointer value
);

  // ========================================================================
  // elaboration checks
  if (PAGE_W < 1 || PAGE_W > 16) begin : g_bad_page
    $error("PAGE_W must be 1..16");
  end

  // ========================================================================
  // helpers
  // mirror the low n bits of a value; bits above n are dropped
  function automatic logic [15:0] mirror(input logic [15:0] v, input logic [3:0] n);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(n)) begin
        r[i] = v[int'(n) - 1 - i];
      end
    end
    return r;
  endfunction

  // ========================================================================
  // register bus state
  logic [15:0] control, next_control;
  logic [15:0] x_circ_start_addr, next_x_circ_start_addr;
  logic [15:0] x_circ_end_addr, next_x_circ_end_addr;
  logic [15:0] y_circ_start_addr, next_y_circ_start_addr;
  logic [15:0] y_circ_end_addr, next_y_circ_end_addr;
  logic [PAGE_W-1:0] data_page_select, next_data_page_select;
  logic [15:0] bitrev_ctl, next_bitrev_ctl;
  logic aw_held, next_aw_held;
  logic [7:0] aw_addr_q, next_aw_addr_q;
  logic w_held, next_w_held;
  logic [31:0] w_data_q, next_w_data_q;
  logic [3:0] w_strb_q, next_w_strb_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] wr_data;
  logic [15:0] wr_mask;
  logic do_write;
  logic last_wrap, last_brev;

  // control fields
  logic x_circ_enable, y_circ_enable;
  logic [3:0] x_circ_pointer_select, y_circ_pointer_select, brev_pointer_select;
  assign x_circ_enable = control[cag_pkg::CTL_X_EN_BIT];
  assign y_circ_enable = control[cag_pkg::CTL_Y_EN_BIT];
  assign x_circ_pointer_select = control[cag_pkg::CTL_X_SEL_LSB +: cag_pkg::SEL_W];
  assign y_circ_pointer_select = control[cag_pkg::CTL_Y_SEL_LSB +: cag_pkg::SEL_W];
  assign brev_pointer_select = control[cag_pkg::CTL_BR_SEL_LSB +: cag_pkg::SEL_W];

  // address and data may arrive in either order; each is held until both are in
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_data = w_held ? w_data_q : wdata;
  assign wr_mask = {{8{(w_held ? w_strb_q[1] : wstrb[1])}},
                    {8{(w_held ? w_strb_q[0] : wstrb[0])}}};

  // write channel and register update
  always_comb begin
    logic aw_now, w_now;
    logic [7:0] wa;
    logic [15:0] nv;
    aw_now = aw_held || (awvalid && awready);
    w_now = w_held || (wvalid && wready);
    wa = aw_held ? aw_addr_q : awaddr;
    nv = 16'h0000;
    next_aw_held = aw_held;
    next_aw_addr_q = aw_addr_q;
    next_w_held = w_held;
    next_w_data_q = w_data_q;
    next_w_strb_q = w_strb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_control = control;
    next_x_circ_start_addr = x_circ_start_addr;
    next_x_circ_end_addr = x_circ_end_addr;
    next_y_circ_start_addr = y_circ_start_addr;
    next_y_circ_end_addr = y_circ_end_addr;
    next_data_page_select = data_page_select;
    next_bitrev_ctl = bitrev_ctl;
    do_write = aw_now && w_now && !bvalid;
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data_q = wdata;
      next_w_strb_q = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = cag_pkg::RESP_OKAY;
      if (wa == cag_pkg::REG_CONTROL) begin
        next_control = (control & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end else if (wa == cag_pkg::REG_X_START) begin
        next_x_circ_start_addr = (x_circ_start_addr & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end else if (wa == cag_pkg::REG_X_END) begin
        next_x_circ_end_addr = (x_circ_end_addr & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end else if (wa == cag_pkg::REG_Y_START) begin
        next_y_circ_start_addr = (y_circ_start_addr & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end else if (wa == cag_pkg::REG_Y_END) begin
        next_y_circ_end_addr = (y_circ_end_addr & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end else if (wa == cag_pkg::REG_PAGE) begin
        nv = (16'(data_page_select) & ~wr_mask) | (wr_data[15:0] & wr_mask);
        next_data_page_select = nv[PAGE_W-1:0];
      end else if (wa == cag_pkg::REG_BITREV) begin
        next_bitrev_ctl = (bitrev_ctl & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end else if (wa != cag_pkg::REG_STATUS) begin
        next_bresp = cag_pkg::RESP_SLVERR; // unmapped; status is read-only, write ignored
      end
    end
  end

  // read channel; unmapped addresses answer slverr with zero data
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = cag_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (araddr == cag_pkg::REG_CONTROL) begin
        next_rdata = {16'h0000, control};
      end else if (araddr == cag_pkg::REG_X_START) begin
        next_rdata = {16'h0000, x_circ_start_addr};
      end else if (araddr == cag_pkg::REG_X_END) begin
        next_rdata = {16'h0000, x_circ_end_addr};
      end else if (araddr == cag_pkg::REG_Y_START) begin
        next_rdata = {16'h0000, y_circ_start_addr};
      end else if (araddr == cag_pkg::REG_Y_END) begin
        next_rdata = {16'h0000, y_circ_end_addr};
      end else if (araddr == cag_pkg::REG_PAGE) begin
        next_rdata = 32'(data_page_select);
      end else if (araddr == cag_pkg::REG_BITREV) begin
        next_rdata = {16'h0000, bitrev_ctl};
      end else if (araddr == cag_pkg::REG_STATUS) begin
        next_rdata[cag_pkg::ST_EA_LSB +: 16] = ea;
        next_rdata[cag_pkg::ST_WRAP_BIT] = last_wrap;
        next_rdata[cag_pkg::ST_BREV_BIT] = last_brev;
      end else begin
        next_rresp = cag_pkg::RESP_SLVERR;
      end
    end
  end

  // register bus flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= cag_pkg::CONTROL_RESET;
      x_circ_start_addr <= 16'h0000;
      x_circ_end_addr <= 16'h0000;
      y_circ_start_addr <= 16'h0000;
      y_circ_end_addr <= 16'h0000;
      data_page_select <= '0;
      bitrev_ctl <= cag_pkg::BITREV_RESET;
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= cag_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= cag_pkg::RESP_OKAY;
    end else begin
      control <= next_control;
      x_circ_start_addr <= next_x_circ_start_addr;
      x_circ_end_addr <= next_x_circ_end_addr;
      y_circ_start_addr <= next_y_circ_start_addr;
      y_circ_end_addr <= next_y_circ_end_addr;
      data_page_select <= next_data_page_select;
      bitrev_ctl <= next_bitrev_ctl;
      aw_held <= next_aw_held;
      aw_addr_q <= next_aw_addr_q;
      w_held <= next_w_held;
      w_data_q <= next_w_data_q;
      w_strb_q <= next_w_strb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ========================================================================
  // address datapath: one request per cycle, answer one cycle later
  logic next_ea_valid, next_wb_valid, next_last_wrap, next_last_brev;
  logic [15:0] next_ea, next_wb_ptr;
  logic [PAGE_W-1:0] next_ea_page;
  logic [3:0] next_wb_ptr_sel;

  always_comb begin
    logic use_x, mod_on, brev_on, is_inc, is_dec, is_pre, is_post, writes_back;
    logic [15:0] delta, lo, hi, step, fld, newp, brmask, corr;
    logic [16:0] blen;
    logic signed [17:0] sum;
    logic up, down, out_page, cross_ok, wrap;
    logic [3:0] sel, nbits;
    // writes always use the x generator; reads pick by space
    use_x = req_write || !req_space_y;
    sel = use_x ? x_circ_pointer_select : y_circ_pointer_select;
    lo = use_x ? x_circ_start_addr : y_circ_start_addr;
    hi = use_x ? x_circ_end_addr : y_circ_end_addr;
    mod_on = (use_x ? x_circ_enable : y_circ_enable) && (sel != cag_pkg::SEL_NONE)
             && (req_ptr_sel == sel);
    is_inc = (req_mode == cag_pkg::cag_mode_post_inc) || (req_mode == cag_pkg::cag_mode_pre_inc);
    is_dec = (req_mode == cag_pkg::cag_mode_post_dec) || (req_mode == cag_pkg::cag_mode_pre_dec);
    is_post = (req_mode == cag_pkg::cag_mode_post_inc) || (req_mode == cag_pkg::cag_mode_post_dec);
    is_pre = (req_mode == cag_pkg::cag_mode_pre_inc) || (req_mode == cag_pkg::cag_mode_pre_dec);
    writes_back = is_inc || is_dec;
    step = req_word ? cag_pkg::STEP_WORD : cag_pkg::STEP_BYTE;
    if (is_inc) begin
      delta = step;
    end else if (is_dec) begin
      delta = 16'(-step);
    end else if (req_mode == cag_pkg::cag_mode_reg_indexed
                 || req_mode == cag_pkg::cag_mode_lit_offset) begin
      delta = req_offset;
    end else begin
      delta = 16'h0000;
    end
    sum = $signed({2'b00, req_ptr}) + $signed({{2{delta[15]}}, delta});
    // movement direction decides which boundary is tested
    up = !delta[15] && (delta != 16'h0000);
    down = delta[15];
    // a carry out of the 16-bit page offset leaves the page; only page 0 edges, or a borrow below page 1, pass
    out_page = sum[17:16] != 2'b00;
    cross_ok = (data_page_select == '0)
               || (data_page_select == PAGE_W'(1) && sum[17]);
    blen = 17'({1'b0, hi}) - 17'({1'b0, lo}) + 17'h0_0001;
    corr = sum[15:0];
    wrap = 1'b0;
    if (mod_on && (!out_page || cross_ok)) begin
      // the up test uses the end address, the down test the start address
      if (up && sum > $signed({2'b00, hi})) begin
        corr = 16'(sum[15:0] - blen[15:0]);
        wrap = 1'b1;
      end else if (down && sum < $signed({2'b00, lo})) begin
        corr = 16'(sum[15:0] + blen[15:0]);
        wrap = 1'b1;
      end
    end
    // reverse-carry step: mirror, add one, mirror back; bit 0 is never touched
    nbits = bitrev_ctl[cag_pkg::BR_BITS_LSB +: cag_pkg::BR_BITS_W];
    brev_on = req_write && is_inc && req_word && bitrev_ctl[cag_pkg::BR_EN_BIT]
              && (brev_pointer_select != cag_pkg::SEL_NONE)
              && (req_ptr_sel == brev_pointer_select);
    brmask = 16'((17'h0_0001 << nbits) - 17'h0_0001) << 1;
    fld = mirror(16'(mirror(16'(req_ptr >> 1), nbits) + 16'h0001), nbits);
    newp = (req_ptr & ~brmask) | (16'(fld << 1) & brmask);
    // bit reversal wins over modulo for word increment writes on the same pointer
    next_ea_valid = req_valid;
    next_wb_valid = req_valid && writes_back;
    next_last_wrap = last_wrap;
    next_last_brev = last_brev;
    next_ea = ea;
    next_wb_ptr = wb_ptr;
    next_wb_ptr_sel = wb_ptr_sel;
    next_ea_page = ea_page;
    if (req_valid) begin
      next_last_wrap = wrap && !brev_on;
      next_last_brev = brev_on;
      next_ea_page = data_page_select;
      next_wb_ptr_sel = req_ptr_sel;
      if (brev_on) begin
        next_ea = is_pre ? newp : req_ptr;
        next_wb_ptr = newp;
      end else begin
        next_ea = is_post ? req_ptr : corr;
        next_wb_ptr = writes_back ? corr : req_ptr;
      end
    end
  end

  // datapath output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ea_valid <= 1'b0;
      ea <= 16'h0000;
      ea_page <= '0;
      wb_valid <= 1'b0;
      wb_ptr_sel <= 4'h0;
      wb_ptr <= 16'h0000;
      last_wrap <= 1'b0;
      last_brev <= 1'b0;
    end else begin
      ea_valid <= next_ea_valid;
      ea <= next_ea;
      ea_page <= next_ea_page;
      wb_valid <= next_wb_valid;
      wb_ptr_sel <= next_wb_ptr_sel;
      wb_ptr <= next_wb_ptr;
      last_wrap <= next_last_wrap;
      last_brev <= next_last_brev;
    end
  end

endmodule

//--- cag_pkg.sv
// shared constants, register map and types for the circular/bit-reversed address generator
package cag_pkg;

  // =====================================================================
  // register byte offsets (axi4-lite, one 32-bit word each)
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_X_START = 8'h04;
  localparam logic [7:0] REG_X_END = 8'h08;
  localparam logic [7:0] REG_Y_START = 8'h0c;
  localparam logic [7:0] REG_Y_END = 8'h10;
  localparam logic [7:0] REG_PAGE = 8'h14;
  localparam logic [7:0] REG_BITREV = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;

  // =====================================================================
  // control register fields
  localparam int CTL_X_EN_BIT = 15;
  localparam int CTL_Y_EN_BIT = 14;
  localparam int CTL_BR_SEL_LSB = 8;
  localparam int CTL_Y_SEL_LSB = 4;
  localparam int CTL_X_SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam logic [SEL_W-1:0] SEL_NONE = 4'hf;
  localparam logic [15:0] CONTROL_RESET = 16'h0fff;

  // bit-reverse control: enable and field width in word-address bits
  localparam int BR_EN_BIT = 15;
  localparam int BR_BITS_LSB = 0;
  localparam int BR_BITS_W = 4;
  localparam logic [15:0] BITREV_RESET = 16'h0000;

  // status fields
  localparam int ST_WRAP_BIT = 0;
  localparam int ST_BREV_BIT = 1;
  localparam int ST_EA_LSB = 16;

  // =====================================================================
  // axi responses and datapath constants
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;

  // addressing modes supplied by the instruction datapath
  typedef enum logic [2:0] {
    cag_mode_plain,
    cag_mode_post_inc,
    cag_mode_pre_inc,
    cag_mode_post_dec,
    cag_mode_pre_dec,
    cag_mode_reg_indexed,
    cag_mode_lit_offset
  } cag_mode_e;

endpackage

//--- cag_circ_addr_gen_props.sv
// concurrent checks on the circular address generator ports
`timescale 1ns/100ps
module cag_circ_props (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic awvalid, // write address valid
  input wire logic awready, // write address ready
  input wire logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic req_valid, // datapath request
  input wire logic [2:0] req_mode, // addressing mode
  input wire logic [3:0] req_ptr_sel, // pointer number
  input wire logic [15:0] req_ptr, // pointer value
  input wire logic ea_valid, // address strobe
  input wire logic [15:0] ea, // effective address
  input wire logic wb_valid, // write-back strobe
  input wire logic [3:0] wb_ptr_sel // write-back pointer
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // =====================================================================
  // named steps: handshakes and request classes
  sequence s_wr_in;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_req_mod;
    req_valid && (req_mode inside {3'd1, 3'd2, 3'd3, 3'd4});
  endsequence
  sequence s_req_keep;
    req_valid && (req_mode inside {3'd5, 3'd6});
  endsequence
  sequence s_req_post;
    req_valid && (req_mode inside {3'd1, 3'd3});
  endsequence
  // =====================================================================
  // datapath answers
  a_ea_follows: assert property (req_valid |=> ea_valid)
    else $error("address strobe missing after request");
  a_ea_no_extra: assert property (!req_valid |=> !ea_valid)
    else $error("address strobe without request");
  a_wb_written: assert property (s_req_mod |=>
      wb_valid && wb_ptr_sel == $past(req_ptr_sel))
    else $error("pointer update missing or wrong pointer");
  a_wb_kept: assert property (s_req_keep |=> !wb_valid)
    else $error("indexed or offset mode changed the pointer");
  a_wb_no_extra: assert property (!req_valid |=> !wb_valid)
    else $error("pointer update without request");
  a_post_ea_old: assert property (s_req_post |=> ea == $past(req_ptr))
    else $error("post mode address is not the old pointer");
  // =====================================================================
  // register bus answers
  a_wr_answer: assert property (s_wr_in |=> bvalid)
    else $error("write response late");
  a_wr_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_rd_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule

bind cag_circ_addr_gen cag_circ_props chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .req_valid,
  .req_mode, .req_ptr_sel, .req_ptr, .ea_valid, .ea, .wb_valid, .wb_ptr_sel);

//--- cag_dp_model.sv
// instruction datapath stand-in: issues pointer requests, captures the answer
`timescale 1ns/100ps
module cag_dp_model (
  input wire logic aclk, // clock
  output logic req_valid, // request strobe
  output logic req_write, // data write
  output logic req_space_y, // y space read
  output logic req_word, // word access
  output logic [2:0] req_mode, // addressing mode
  output logic [3:0] req_ptr_sel, // pointer number
  output logic [15:0] req_ptr, // pointer value
  output logic [15:0] req_offset, // offset
  input wire logic ea_valid, // address strobe
  input wire logic [15:0] ea, // effective address
  input wire logic wb_valid, // write-back strobe
  input wire logic [15:0] wb_ptr // new pointer
);
  logic got_eav;
  logic got_wbv;
  logic [15:0] got_ea;
  logic [15:0] got_wb;
  initial begin
    {req_valid, req_write, req_space_y, req_word, req_mode} = '0;
    {req_ptr_sel, req_ptr, req_offset} = '0;
  end
  // one request pulse; pointer and offset flip afterwards so stale values are never trusted
  task automatic issue(input logic w, y, wd, input logic [2:0] m, input logic [3:0] s,
                       input logic [15:0] p, o);
    @(posedge aclk);
    req_valid <= 1'b1;
    {req_write, req_space_y, req_word, req_mode, req_ptr_sel} <= {w, y, wd, m, s};
    req_ptr <= p;
    req_offset <= o;
    @(posedge aclk);
    req_valid <= 1'b0;
    req_ptr <= ~p;
    req_offset <= ~o;
    #1;
    {got_eav, got_wbv, got_ea, got_wb} = {ea_valid, wb_valid, ea, wb_ptr};
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the circular address generator
`timescale 1ns/100ps
module testbench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, ea_valid, wb_valid;
  logic req_valid, req_write, req_space_y, req_word;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf, req_ptr_sel, wb_ptr_sel;
  logic [1:0] bresp, rresp, r;
  logic [2:0] req_mode;
  logic [15:0] req_ptr, req_offset, ea, wb_ptr;
  logic [8:0] ea_page;
  logic [31:0] d;
  int n_errors = 0, checked = 0;
  int n;
  always #10 aclk = ~aclk;
  cag_circ_addr_gen dut_u (.*);
  cag_dp_model dp_u (.*);
  // =====================================================================
  // comparison, closing and bus tasks
  task chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // write: offer address and data together, release each once taken
  task axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    r = bresp;
    if (n == 50) begin
      n_errors++;
      stop_test();
    end
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    {r, d} = {rresp, rdata};
    if (n == 50) begin
      n_errors++;
      stop_test();
    end
  endtask
  // one datapath request and its four answers
  task rq(input logic w, y, wd, input logic [2:0] m, input logic [3:0] s,
          input logic [15:0] p, o, e, input logic v, input logic [15:0] b);
    dp_u.issue(w, y, wd, m, s, p, o);
    chk("ea_valid", dp_u.got_eav, 1'b1);
    chk("ea", dp_u.got_ea, e);
    chk("wb_valid", dp_u.got_wbv, v);
    if (v) chk("wb_ptr", dp_u.got_wb, b);
  endtask
  // =====================================================================
  // scenarios
  task t_regs;
    axr(8'h00);
    chk("control reset", d, 32'h0000_0fff);
    axr(8'h20);
    chk("unmapped resp", r, cag_pkg::RESP_SLVERR);
    axw(8'h20, 32'h0000_0000);
    chk("unmapped bresp", r, cag_pkg::RESP_SLVERR);
    // page, bounds, selects, then enables; 16-byte buffers aligned both ways
    axw(cag_pkg::REG_PAGE, 32'h5);
    axw(cag_pkg::REG_X_START, 32'h1000);
    axw(cag_pkg::REG_X_END, 32'h100f);
    axw(cag_pkg::REG_Y_END, 32'h200f);
    axw(cag_pkg::REG_Y_START, 32'h2000);
    axw(cag_pkg::REG_BITREV, 32'h8004);
    axw(cag_pkg::REG_CONTROL, 32'h0421);
    axw(cag_pkg::REG_CONTROL, 32'hc421);
    chk("bresp", r, cag_pkg::RESP_OKAY);
    axr(cag_pkg::REG_CONTROL);
    chk("control", d, 32'h0000_c421);
    $display("regs done");
  endtask
  task t_wrap;
    rq(0, 0, 1, 3'd1, 4'd1, 16'h100e, 0, 16'h100e, 1, 16'h1000);
    rq(0, 0, 1, 3'd2, 4'd1, 16'h100e, 0, 16'h1000, 1, 16'h1000);
    chk("ea_page", ea_page, 9'h005);
    rq(0, 1, 1, 3'd3, 4'd2, 16'h2000, 0, 16'h2000, 1, 16'h200e);
    rq(0, 1, 1, 3'd4, 4'd2, 16'h2000, 0, 16'h200e, 1, 16'h200e);
    rq(0, 0, 1, 3'd6, 4'd1, 16'h1008, 16'h000c, 16'h1004, 0, 0);
    rq(0, 0, 1, 3'd5, 4'd1, 16'h1002, 16'hfffa, 16'h100c, 0, 0);
    rq(0, 0, 0, 3'd3, 4'd1, 16'h1000, 0, 16'h1000, 1, 16'h100f);
    // status holds the last address and its wrap flag
    axr(cag_pkg::REG_STATUS);
    chk("status wrap", d, 32'h1000_0001);
    $display("wrap done");
  endtask
  task t_select;
    rq(0, 0, 1, 3'd1, 4'd3, 16'h100e, 0, 16'h100e, 1, 16'h1010);
    axw(cag_pkg::REG_CONTROL, 32'h4421);
    rq(0, 0, 1, 3'd2, 4'd1, 16'h100e, 0, 16'h1010, 1, 16'h1010);
    // enabled but x select parked at 15: no correction even for pointer 15
    axw(cag_pkg::REG_CONTROL, 32'hc42f);
    rq(0, 0, 1, 3'd2, 4'd15, 16'h100e, 0, 16'h1010, 1, 16'h1010);
    axw(cag_pkg::REG_CONTROL, 32'hc421);
    $display("select done");
  endtask
  // word index walks 0, 8, 4, 12, 2 for a 4-bit field
  task t_bitrev;
    logic [15:0] seq [5];
    seq = '{16'h3000, 16'h3010, 16'h3008, 16'h3018, 16'h3004};
    for (int i = 0; i < 4; i++) begin
      rq(1, 0, 1, 3'd1, 4'd4, seq[i], 0, seq[i], 1, seq[i+1]);
    end
    axr(cag_pkg::REG_STATUS);
    chk("status brev", d, 32'h3018_0002);
    rq(0, 0, 1, 3'd1, 4'd4, 16'h3000, 0, 16'h3000, 1, 16'h3002);
    rq(1, 0, 0, 3'd1, 4'd4, 16'h3000, 0, 16'h3000, 1, 16'h3001);
    $display("bitrev done");
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_wrap();
    t_select();
    t_bitrev();
    stop_test();
  end
endmodule
